// ---- hdl/otl_loader.sv ----
// Option trim loader: reads option bytes from flash during reset, holds the
// hidden option registers and the working trim bytes, and offers trim access
// over an AXI4-Lite slave.
// Assumes the flash array answers a read in the cycle after its address,
// and that the core is held in reset until o_load_done is high.
// Trim bytes beyond the load window start unknown until software writes them.
//
// Notes on behaviour
// - New option values take effect only through the load at the next reset.
// - Every reset, system or stop recovery, reloads option bytes from flash.
// - Load completes and drives outputs before the core leaves reset.
// - Option registers are not software visible; bus accesses never touch them.
// - User option bytes come from program addresses zero and one.
// - Factory trim bytes live in the information page.
// - Software trim writes only change volatile copies; next load restores flash for trim bytes 00h-0Ah only.
// - Index write then data write replaces the indexed working trim byte.
// - Index write then data read returns the indexed working trim byte.
// - Trim index 00h-1Fh selects information bytes 20h-3Fh.
// - No other information byte is reachable through index and data.
// - Reset load does 43 reads; six counter bits form the low address.
// - Option registers capture flash data selected by the counter, 43 bytes max.
// - First two bytes from program memory, the rest from information area.
// - Trim index: 8-bit read-write at FF6h, reset zero.
// - Trim value: 8-bit read-write at FF7h, reset zero.
// - Option bit 7: watchdog timeout action, 0 interrupt, 1 reset.
// - Option bit 6: 0 watchdog forced on from power-up, 1 armed by instruction.
// - Option bits 5:4: oscillator drive select, 11 erased default.
// - Option bit 3: 0 brown-out off in stop, 1 kept on.
// - Option bit 2: 0 protects code and limits debug, 1 open.
// - Option bit 0: 0 blocks user program and erase, 1 allows them.
`timescale 1ns/100ps
`include "otl_map.svh"

module otl_loader #(
   parameter int ADDR_W = 14,
   parameter int FLASH_AW = 16
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_stop_recovery,
   // Flash read port
   output logic [FLASH_AW-1:0] o_flash_addr,
   output logic o_flash_info_sel,
   output logic o_flash_rd,
   input wire logic [7:0] i_flash_data,
   // Option outputs
   output otl_pkg::otl_opts_s o_opts,
   output logic o_load_done,
   output logic [255:0] o_trim_bytes,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);

   // Register word index times four must fit the bus address
   if (ADDR_W < 14) begin : g_bad_addr_w
      $error("otl_loader: ADDR_W below 14");
   end

   // The six-bit load counter forms the low flash address bits
   if (FLASH_AW < 6) begin : g_bad_flash_aw
      $error("otl_loader: FLASH_AW below 6");
   end

   // Load length must fit the six-bit counter and reach the trim window
   if (`OTL_LOAD_READS > 64 || `OTL_LOAD_READS <= `OTL_TRIM_BASE) begin : g_bad_reads
      $error("otl_loader: load length does not fit the counter");
   end

   // Working bytes are selected by five index bits
   if (`OTL_TRIM_COUNT != 32) begin : g_bad_trims
      $error("otl_loader: trim count must be 32");
   end

   //--------------------------------------------------------------
   // Loader state
   //--------------------------------------------------------------
   localparam logic [5:0] LAST_CNT = 6'(`OTL_LOAD_READS - 1);

   otl_pkg::otl_state_e state_reg, state_next;
   logic [5:0] cnt_reg, cnt_next;
   logic cap_reg, cap_next;
   logic [5:0] cap_addr_reg, cap_addr_next;
   logic [7:0] opt0_reg, opt0_next;
   logic [7:0] opt1_reg, opt1_next;
   otl_pkg::otl_opts_s opts_reg, opts_next;
   logic [7:0] trim_reg [`OTL_TRIM_COUNT];
   logic [7:0] trim_next [`OTL_TRIM_COUNT];
   logic [7:0] index_reg, index_next;
   logic [7:0] value_reg, value_next;

   // Stop recovery is a second reload trigger; pin input synchronised first
   logic stop_m_reg, stop_s_reg, stop_d_reg;
   logic reload;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         stop_m_reg <= 1'b0;
         stop_s_reg <= 1'b0;
         stop_d_reg <= 1'b0;
      end else begin
         stop_m_reg <= i_stop_recovery;
         stop_s_reg <= stop_m_reg;
         stop_d_reg <= stop_s_reg;
      end
   end

   // An edge that arrives mid-load is dropped; that load already refreshes everything
   assign reload = stop_s_reg & ~stop_d_reg;

   // Counter selects program bytes 0..1 then information bytes 2..42
   function automatic logic is_user(input logic [5:0] a);
      is_user = a < 6'(`OTL_USER_BYTES);
   endfunction : is_user

   // Erased option bits mean the safe defaults; three bits are active low
   function automatic otl_pkg::otl_opts_s opts_of(input logic [7:0] b);
      opts_of.watchdog_timeout_action = b[`OTL_BIT_WDT_ACTION];
      opts_of.watchdog_forced_on = ~b[`OTL_BIT_WDT_FORCED];
      opts_of.oscillator_drive_select =
         otl_pkg::otl_osc_e'(b[`OTL_BIT_OSC_HI:`OTL_BIT_OSC_LO]);
      opts_of.brownout_stop_keepalive = b[`OTL_BIT_BO_KEEP];
      opts_of.code_read_protect = ~b[`OTL_BIT_READ_PROT];
      opts_of.code_write_protect = ~b[`OTL_BIT_WRITE_PROT];
   endfunction : opts_of

   //--------------------------------------------------------------
   // AXI4-Lite state
   //--------------------------------------------------------------
   logic aw_reg, aw_next;
   logic [ADDR_W-1:0] awa_reg, awa_next;
   logic w_reg, w_next;
   logic [7:0] wd_reg, wd_next;
   logic wst_reg, wst_next;
   logic bv_reg, bv_next;
   logic [1:0] br_reg, br_next;
   logic rv_reg, rv_next;
   logic [31:0] rd_reg, rd_next;
   logic [1:0] rr_reg, rr_next;

   // Each register takes one word; its byte address is four times its offset
   function automatic logic [1:0] decode(input logic [ADDR_W-1:0] a);
      decode = 2'd0;
      if (a[1:0] == 2'b00) begin
         if (a[ADDR_W-1:2] == (ADDR_W-2)'(`OTL_TRIM_INDEX_OFS)) begin
            decode = 2'd1;
         end else if (a[ADDR_W-1:2] == (ADDR_W-2)'(`OTL_TRIM_VALUE_OFS)) begin
            decode = 2'd2;
         end
      end
   endfunction : decode

   logic do_wr, do_rd;
   logic [1:0] wsel, rsel;
   logic idx_ok;

   // Bus stays shut until the last captured byte has landed
   assign o_awready = ~aw_reg & ~bv_reg & o_load_done;
   assign o_wready = ~w_reg & ~bv_reg & o_load_done;
   assign o_arready = ~rv_reg & o_load_done;
   assign do_wr = aw_reg & w_reg & ~bv_reg;
   assign do_rd = i_arvalid & o_arready;
   assign wsel = decode(awa_reg);
   assign rsel = decode(i_araddr);
   assign idx_ok = index_reg < 8'(`OTL_TRIM_COUNT);

   //--------------------------------------------------------------
   // Next state
   //--------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      cap_next = 1'b0;
      cap_addr_next = cnt_reg;
      opt0_next = opt0_reg;
      opt1_next = opt1_reg;
      unique case (state_reg)
         otl_pkg::OTL_ST_IDLE: begin
            state_next = otl_pkg::OTL_ST_LOAD;
            cnt_next = 6'h00;
         end
         otl_pkg::OTL_ST_LOAD: begin
            cap_next = 1'b1;
            if (cnt_reg == LAST_CNT) begin
               state_next = otl_pkg::OTL_ST_DONE;
            end else begin
               cnt_next = cnt_reg + 6'h01;
            end
         end
         otl_pkg::OTL_ST_DONE: begin
            if (reload) begin
               state_next = otl_pkg::OTL_ST_LOAD;
               cnt_next = 6'h00;
            end
         end
         default: state_next = otl_pkg::OTL_ST_IDLE;
      endcase
      // Capture lands one cycle after each address, on the matching counter value
      if (cap_reg) begin
         if (cap_addr_reg == 6'h00) begin
            opt0_next = i_flash_data;
         end else if (cap_addr_reg == 6'h01) begin
            opt1_next = i_flash_data;
         end
      end
      opts_next = opts_of(opt0_next);
   end

   //--------------------------------------------------------------
   // Trim and bus next state
   //--------------------------------------------------------------
   always_comb begin
      trim_next = trim_reg;
      index_next = index_reg;
      value_next = value_reg;
      aw_next = aw_reg;
      awa_next = awa_reg;
      w_next = w_reg;
      wd_next = wd_reg;
      wst_next = wst_reg;
      bv_next = bv_reg;
      br_next = br_reg;
      rv_next = rv_reg;
      rd_next = rd_reg;
      rr_next = rr_reg;
      // Only eleven trim bytes lie inside the 43-read window; the rest keep software values
      if (cap_reg && cap_addr_reg >= `OTL_TRIM_BASE) begin
         trim_next[cap_addr_reg[4:0]] = i_flash_data;
      end
      // Write channel: address and data taken in either order
      if (i_awvalid && o_awready) begin
         aw_next = 1'b1;
         awa_next = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         w_next = 1'b1;
         wd_next = i_wdata[7:0];
         wst_next = i_wstrb[0];
      end
      if (do_wr) begin
         aw_next = 1'b0;
         w_next = 1'b0;
         bv_next = 1'b1;
         // Unmapped offsets answer with a slave error and change nothing
         br_next = (wsel == 2'd0) ? 2'b10 : 2'b00;
         if (wst_reg && wsel == 2'd1) begin
            index_next = wd_reg;
         end
         if (wst_reg && wsel == 2'd2) begin
            value_next = wd_reg;
            if (idx_ok) begin
               trim_next[index_reg[4:0]] = wd_reg;
            end
         end
      end
      if (bv_reg && i_bready) begin
         bv_next = 1'b0;
      end
      if (do_rd) begin
         rv_next = 1'b1;
         rr_next = (rsel == 2'd0) ? 2'b10 : 2'b00;
         unique case (rsel)
            2'd1: rd_next = {24'h00_0000, index_reg};
            2'd2: rd_next = {24'h00_0000, idx_ok ? trim_reg[index_reg[4:0]] : 8'h00};
            default: rd_next = 32'h0000_0000;
         endcase
      end else if (rv_reg && i_rready) begin
         rv_next = 1'b0;
      end
   end

   //--------------------------------------------------------------
   // Registers
   //--------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_reg <= otl_pkg::OTL_ST_IDLE;
         cnt_reg <= 6'h00;
         cap_reg <= 1'b0;
         cap_addr_reg <= 6'h00;
         opt0_reg <= `OTL_ERASED_BYTE;
         opt1_reg <= `OTL_ERASED_BYTE;
         opts_reg <= opts_of(`OTL_ERASED_BYTE);
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         cap_reg <= cap_next;
         cap_addr_reg <= cap_addr_next;
         opt0_reg <= opt0_next;
         opts_reg <= opts_next;
         opt1_reg <= opt1_next;
      end
   end

   //--------------------------------------------------------------
   // Trim index and bus registers
   //--------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         index_reg <= `OTL_INDEX_RST;
         value_reg <= `OTL_VALUE_RST;
         aw_reg <= 1'b0;
         awa_reg <= '0;
         w_reg <= 1'b0;
         wd_reg <= 8'h00;
         wst_reg <= 1'b0;
         bv_reg <= 1'b0;
         br_reg <= 2'b00;
         rv_reg <= 1'b0;
         rd_reg <= 32'h0000_0000;
         rr_reg <= 2'b00;
      end else begin
         index_reg <= index_next;
         value_reg <= value_next;
         aw_reg <= aw_next;
         awa_reg <= awa_next;
         w_reg <= w_next;
         wd_reg <= wd_next;
         wst_reg <= wst_next;
         bv_reg <= bv_next;
         br_reg <= br_next;
         rv_reg <= rv_next;
         rd_reg <= rd_next;
         rr_reg <= rr_next;
      end
   end

   // Working trim copies keep their value through reset; only the load refreshes them
   always_ff @(posedge i_mclk) begin
      trim_reg <= trim_next;
   end

   //--------------------------------------------------------------
   // Outputs
   //--------------------------------------------------------------
   // Options change only by the reset load, never while running
   logic in_load;
   assign in_load = (state_reg != otl_pkg::OTL_ST_DONE) | cap_reg;

   assign o_opts = opts_reg;

   assign o_load_done = ~in_load;
   assign o_flash_addr = {{(FLASH_AW-6){1'b0}}, cnt_reg};
   assign o_flash_info_sel = ~is_user(cnt_reg);
   assign o_flash_rd = (state_reg == otl_pkg::OTL_ST_LOAD);

   genvar g;
   generate
      for (g = 0; g < `OTL_TRIM_COUNT; g++) begin : g_trim
         assign o_trim_bytes[g*8 +: 8] = trim_reg[g];
      end
   endgenerate

   assign o_bvalid = bv_reg;
   assign o_bresp = br_reg;
   assign o_rvalid = rv_reg;
   assign o_rdata = rd_reg;
   assign o_rresp = rr_reg;

endmodule : otl_loader

// ---- hdl/otl_map.svh ----
// Offsets, field positions, reset values and timing counts of the option trim loader.
// Assumes inclusion by its bare name from the design file.
`ifndef OTL_MAP_SVH
`define OTL_MAP_SVH

`define OTL_TRIM_INDEX_OFS 12'hff6
`define OTL_TRIM_VALUE_OFS 12'hff7
`define OTL_INDEX_RST 8'h00
`define OTL_VALUE_RST 8'h00
`define OTL_LOAD_READS 43
`define OTL_TRIM_COUNT 32
`define OTL_TRIM_BASE 6'h20
`define OTL_USER_BYTES 2
`define OTL_BIT_WDT_ACTION 7
`define OTL_BIT_WDT_FORCED 6
`define OTL_BIT_OSC_HI 5
`define OTL_BIT_OSC_LO 4
`define OTL_BIT_BO_KEEP 3
`define OTL_BIT_READ_PROT 2
`define OTL_BIT_WRITE_PROT 0
`define OTL_ERASED_BYTE 8'hff

`endif

// ---- hdl/otl_pkg.sv ----
// Types shared by the option trim loader.
// Assumes nothing beyond the map header.
package otl_pkg;

   typedef enum logic [1:0] {
      OTL_OSC_RC = 2'b00,
      OTL_OSC_LOW = 2'b01,
      OTL_OSC_MED = 2'b10,
      OTL_OSC_HIGH = 2'b11
   } otl_osc_e;

   typedef struct packed {
      logic watchdog_timeout_action;
      logic watchdog_forced_on;
      otl_osc_e oscillator_drive_select;
      logic brownout_stop_keepalive;
      logic code_read_protect;
      logic code_write_protect;
   } otl_opts_s;

   typedef enum logic [1:0] {
      OTL_ST_IDLE = 2'b00,
      OTL_ST_LOAD = 2'b01,
      OTL_ST_DONE = 2'b11
   } otl_state_e;

endpackage : otl_pkg

// ---- verification/otl_flash_model.sv ----
// Flash array model: program bytes and information page.
// Assumes one read a cycle, data the cycle after the address.
`timescale 1ns/100ps
module otl_flash_model (
   input wire logic i_mclk,
   input wire logic [15:0] i_addr,
   input wire logic i_info,
   input wire logic i_rd,
   input wire logic [7:0] i_prog0,
   output logic [7:0] o_data
);
   logic [7:0] data_reg = 8'h00;
   logic [7:0] data_next;
   always_comb begin
      // Idle bus toggles so a stale byte never looks valid
      data_next = ~data_reg;
      if (i_rd && i_info) begin
         data_next = i_addr[7:0] ^ 8'h5a;
      end else if (i_rd) begin
         data_next = (i_addr == 16'h0000) ? i_prog0 : (i_addr == 16'h0001) ? 8'hff : 8'h00;
      end
   end
   always_ff @(posedge i_mclk) begin
      data_reg <= data_next;
   end
   assign o_data = data_reg;
endmodule : otl_flash_model

// ---- verification/otl_loader_assertions.sv ----
// Port checker of the option trim loader.
// Assumes binding to otl_loader.
`timescale 1ns/100ps
module otl_chk #(
   parameter int ADDR_W = 12,
   parameter int FLASH_AW = 16
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_stop_recovery,
   input wire logic [FLASH_AW-1:0] o_flash_addr,
   input wire logic o_flash_info_sel,
   input wire logic o_flash_rd,
   input wire otl_pkg::otl_opts_s o_opts,
   input wire logic o_load_done,
   input wire logic o_awready,
   input wire logic o_wready,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic [31:0] o_rdata
);
   logic [5:0] n_reg, n_next;
   always_comb begin
      n_next = o_flash_rd ? n_reg + 6'h01 : 6'h00;
   end
   always_ff @(posedge i_mclk) begin
      n_reg <= i_rst ? 6'h00 : n_next;
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   a_bus_shut_load: assert property (!o_load_done |-> !o_awready && !o_wready && !o_arready)
      else $error("bus open during load");
   a_addr_upper_zero: assert property (o_flash_rd |-> o_flash_addr[FLASH_AW-1:6] == '0)
      else $error("upper flash address not zero");
   a_page_select: assert property (o_flash_rd |-> o_flash_info_sel == (o_flash_addr[5:0] > 6'h01))
      else $error("wrong flash page");
   a_read_count: assert property ($fell(o_flash_rd) |-> n_reg == 6'h2b)
      else $error("load read count wrong");
   a_addr_step: assert property (o_flash_rd && $past(o_flash_rd) |-> o_flash_addr == $past(o_flash_addr) + 1'b1)
      else $error("load address not stepping");
   a_done_after_load: assert property ($fell(o_flash_rd) |-> ##[0:3] o_load_done)
      else $error("done missing after load");
   a_opts_hold: assert property (o_load_done && $past(o_load_done) |-> $stable(o_opts))
      else $error("options changed while running");
   a_erased_reset: assert property (disable iff (1'b0) $past(i_rst) |-> o_opts == 7'h5c)
      else $error("options not erased in reset");
   a_stop_reload: assert property ($rose(i_stop_recovery) |-> ##[1:8] o_flash_rd)
      else $error("no reload on stop recovery");
   a_rdata_width: assert property (o_rvalid |-> o_rdata[31:8] == 24'h00_0000)
      else $error("read data above byte lane");
endmodule : otl_chk
bind otl_loader otl_chk #(.ADDR_W(ADDR_W), .FLASH_AW(FLASH_AW)) otl_chk_inst (.i_mclk, .i_rst,
   .i_stop_recovery, .o_flash_addr, .o_flash_info_sel, .o_flash_rd, .o_opts, .o_load_done,
   .o_awready, .o_wready, .o_arready, .o_rvalid, .o_rdata);

// ---- verification/otl_loader_tb.sv ----
// Testbench of the option trim loader with flash model and AXI4-Lite master.
// Assumes design, checker and flash model are compiled first.
`timescale 1ns/100ps
module otl_loader_tb;
   localparam logic [13:0] IXA = 14'h0ff6 << 2;
   localparam logic [13:0] VXA = 14'h0ff7 << 2;
   logic i_mclk = 0, i_rst = 1, i_stop_recovery = 0, i_awvalid = 0, i_wvalid = 0;
   logic i_bready = 0, i_arvalid = 0, i_rready = 0;
   logic [13:0] i_awaddr = 0, i_araddr = 0;
   logic [31:0] i_wdata = 0, o_rdata;
   logic [3:0] i_wstrb = 4'hf;
   logic [7:0] i_flash_data, p0 = 8'hff;
   logic [15:0] o_flash_addr;
   logic o_flash_info_sel, o_flash_rd, o_load_done, o_awready, o_wready, o_bvalid;
   logic o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp;
   logic [255:0] o_trim_bytes, tr, tf, tm;
   // The 43-read load reaches only the first eleven trim bytes; tm marks known bytes
   localparam int NL = 43 - 32;
   otl_pkg::otl_opts_s o_opts;
   int mismatches = 0, n_compared = 0, cyc = 0, seed;
   logic [33:0] q[$];
   otl_loader #(.ADDR_W(14)) otl_loader_inst (.i_mclk, .i_rst, .i_stop_recovery, .o_flash_addr,
      .o_flash_info_sel, .o_flash_rd, .i_flash_data, .o_opts, .o_load_done, .o_trim_bytes,
      .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
      .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
      .i_rready);
   otl_flash_model otl_flash_model_inst (.i_mclk, .i_addr(o_flash_addr),
      .i_info(o_flash_info_sel), .i_rd(o_flash_rd), .i_prog0(p0), .o_data(i_flash_data));
   initial begin
      forever #20 i_mclk = ~i_mclk;
   end
   // ----------------------------------------
   // Checks and bus tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [255:0] e, input logic [255:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   function automatic logic [6:0] ox(input logic [7:0] p);
      return {p[7], ~p[6], p[5:4], p[3], ~p[2], ~p[0]};
   endfunction : ox
   task automatic wt(input logic v);
      int n;
      for (n = 0; n < 200 && o_load_done !== v; n++) @(posedge i_mclk);
      chk("done", v, o_load_done);
   endtask : wt
   task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] r);
      @(posedge i_mclk);
      q.push_back({r, 32'h0000_0000});
      i_awaddr <= a;
      i_wdata <= {24'h00_0000, d};
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do begin
         @(posedge i_mclk);
         if (i_awvalid && o_awready === 1'b1) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready === 1'b1) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1);
      i_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [13:0] a, input logic [7:0] d, input logic [1:0] r);
      @(posedge i_mclk);
      q.push_back({r, 24'h00_0000, d});
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do begin
         @(posedge i_mclk);
         if (i_arvalid && o_arready === 1'b1) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1);
      i_rready <= 1'b0;
   endtask : rd
   // Response watcher; bounded run
   always @(posedge i_mclk) begin
      if ((o_bvalid === 1'b1 && i_bready) || (o_rvalid === 1'b1 && i_rready)) begin
         if (q.size() == 0) chk("queue", 1, 0);
         else chk("resp", q.pop_front(), o_bvalid ? {o_bresp, 32'h0} : {o_rresp, o_rdata});
      end
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      int k, j;
      logic [7:0] d, p, pv;
      seed = 32'h56c4_ab14;
      for (k = 0; k < 32; k++) tf[8*k +: 8] = (8'h20 + 8'(k)) ^ 8'h5a;
      tr = tf;
      tm = (256'd1 << (8 * NL)) - 256'd1;
      pv = 8'hff;
      repeat (12) @(posedge i_mclk);
      i_rst <= 1'b0;
      wt(1'b1);
      chk("opts", ox(8'hff), o_opts);
      chk("trims", tf & tm, o_trim_bytes & tm);
      rd(IXA, 8'h00, 2'b00);
      for (k = 0; k < 6; k++) begin
         j = (k < 2) ? k * 31 : $random(seed) & 31;
         d = 8'($random(seed));
         wr(IXA, 8'(j), 2'b00);
         wr(VXA, d, 2'b00);
         rd(VXA, d, 2'b00);
         tr[8*j +: 8] = d;
         tm[8*j +: 8] = 8'hff;
      end
      chk("trims", tr & tm, o_trim_bytes & tm);
      wr(IXA, 8'h05, 2'b00);
      i_wstrb <= 4'he;
      wr(VXA, ~tr[47:40], 2'b00);
      i_wstrb <= 4'hf;
      rd(VXA, tr[47:40], 2'b00);
      wr(IXA, 8'h20, 2'b00);
      wr(VXA, 8'h3c, 2'b00);
      rd(VXA, 8'h00, 2'b00);
      rd(IXA, 8'h20, 2'b00);
      chk("trims", tr & tm, o_trim_bytes & tm);
      wr(14'h0100, 8'h55, 2'b10);
      rd(14'h0100, 8'h00, 2'b10);
      tr[8*NL-1:0] = tf[8*NL-1:0];
      for (k = 0; k < 4; k++) begin
         p = {k[0], k[1], k[1], k[0], ~k[0], k[1], 1'b1, k[0]};
         p0 <= p;
         repeat (3) @(posedge i_mclk);
         chk("opts", ox(pv), o_opts);
         i_stop_recovery <= 1'b1;
         wt(1'b0);
         i_stop_recovery <= 1'b0;
         wt(1'b1);
         chk("opts", ox(p), o_opts);
         chk("trims", tr & tm, o_trim_bytes & tm);
         pv = p;
      end
      i_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      wt(1'b1);
      chk("opts", ox(pv), o_opts);
      chk("trims", tr & tm, o_trim_bytes & tm);
      rd(IXA, 8'h00, 2'b00);
      give_verdict();
   end
endmodule : otl_loader_tb
